// file: verilog/rpds_pkg.sv
// Constants for the reset, protection and debug-select block
package rpds_pkg;

  // ****************************************************************
  // Register bus geometry and offsets
  // ****************************************************************
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam logic [7:0]  OFS_CTRL        = 8'h00;
  localparam logic [7:0]  OFS_STATUS      = 8'h04;
  localparam logic [7:0]  OFS_BOD_CFG     = 8'h08;
  localparam logic [7:0]  OFS_DEBUG       = 8'h0C;
  localparam logic [7:0]  OFS_CAPS        = 8'h10;
  localparam logic [7:0]  OFS_PROT        = 8'h14;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int          CTRL_PIN_RST    = 0;
  localparam int          CTRL_CLK_LO     = 1;
  localparam int          CTRL_REMAP      = 3;
  localparam int          CTRL_ISP_DIS    = 4;
  localparam int          BOD_IRQ_SEL     = 0;
  localparam int          BOD_RST_SEL     = 1;
  localparam int          BOD_RST_EN      = 2;
  localparam int          ST_FLAGS_LO     = 0;
  localparam int          ST_BOD_RAW      = 4;
  localparam int          ST_BOD_SEEN     = 5;
  localparam int          ST_SCAN         = 6;
  localparam int          DBG_WATCH_LO    = 8;
  localparam int          CAPS_WATCH_LO   = 4;
  localparam int          PROT_NO_ISP     = 2;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        RST_PIN_FUNC    = 1'b1;
  localparam logic        RST_REMAP       = 1'b1;
  localparam logic [2:0]  RST_BOD_CFG     = 3'h0;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [2:0]  PM_ACTIVE       = 3'h0;
  localparam logic [2:0]  PM_SLEEP        = 3'h1;
  localparam logic [2:0]  PM_DEEP_SLEEP   = 3'h2;
  localparam logic [2:0]  PM_POWER_DOWN   = 3'h3;
  localparam logic [2:0]  PM_DEEP_PD      = 3'h4;
  localparam logic [1:0]  PROT_NONE       = 2'h0;
  localparam logic [1:0]  PROT_L1         = 2'h1;
  localparam logic [1:0]  PROT_L2         = 2'h2;
  localparam logic [1:0]  PROT_L3         = 2'h3;
  localparam logic [1:0]  ISP_FULL        = 2'h0;
  localparam logic [1:0]  ISP_LIMITED     = 2'h1;
  localparam logic [1:0]  ISP_REDUCED     = 2'h2;
  localparam logic [1:0]  ISP_NONE        = 2'h3;
  localparam logic [1:0]  CLK_SRC_IRC     = 2'h0;
  localparam logic [31:0] BOOT_FETCH_ADDR = 32'h0000_0000;

  // ****************************************************************
  // Asynchronous input indices and timing
  // ****************************************************************
  localparam int          N_SYNC          = 7;
  localparam int          SY_PIN          = 0;
  localparam int          SY_WDT          = 1;
  localparam int          SY_POR          = 2;
  localparam int          SY_BOD0         = 3;
  localparam int          SY_BOD1         = 4;
  localparam int          SY_BOOT         = 5;
  localparam int          SY_TRST         = 6;
  localparam int          CLK_PERIOD_NS   = 10;
  localparam int          PIN_PULSE_NS    = 50;
  localparam int          PIN_PULSE_CYC   = (PIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// file: verilog/rpds_top.sv
// Reset merge, brownout, read protection and debug port selection
//
// The address-and-strobe port and the register offsets were left to the implementer.
module rpds_top
  import rpds_pkg::*;
#(
  parameter int          NUM_BKPT     = 4,
  parameter int          NUM_WATCH    = 2,
  parameter logic [31:0] PAT_PROT_L1  = 32'h0000_0001,
  parameter logic [31:0] PAT_PROT_L2  = 32'h0000_0002,
  parameter logic [31:0] PAT_PROT_L3  = 32'h0000_0003,
  parameter logic [31:0] PAT_NO_ISP   = 32'h0000_0004
) (
  // Clock and block reset
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  // Register port
  input  wire logic [ADDR_W-1:0]    reg_addr,
  input  wire logic [DATA_W-1:0]    reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [DATA_W-1:0]    reg_rdata,
  // Asynchronous reset sources and pins
  input  wire logic                 reset_capable_pin_n,
  input  wire logic                 wdt_reset_req,
  input  wire logic                 por_req,
  input  wire logic [1:0]           brownout_below,
  input  wire logic                 boot_select_pin_n,
  input  wire logic                 trst_n,
  // Power mode from the power manager
  input  wire logic [2:0]           power_mode,
  // Flash controller
  input  wire logic                 flash_init_done,
  input  wire logic [31:0]          flash_prot_word,
  output logic                      flash_init_req,
  // Chip reset and clocking
  output logic                      chip_rst_n,
  output logic                      reset_status_out,
  output logic                      internal_rc_osc_en,
  output logic      [1:0]           clk_src_sel,
  output logic                      wake_req,
  // Processor start
  output logic                      cpu_start,
  output logic      [31:0]          cpu_start_addr,
  output logic                      boot_remap,
  // Brownout interrupt to the nested interrupt controller
  output logic                      brownout_irq,
  // Access control
  output logic                      swd_en,
  output logic                      scan_en,
  output logic                      core_debug_en,
  output logic      [1:0]           isp_level,
  output logic                      isp_sector0_lock,
  output logic                      isp_erase_only,
  output logic                      isp_boot_entry,
  output logic                      in_app_programming_en,
  output logic      [NUM_BKPT-1:0]  bkpt_en,
  output logic      [NUM_WATCH-1:0] watch_en
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  // Debug unit has no more comparators than these
  if (NUM_BKPT < 1 || NUM_BKPT > 4 || NUM_WATCH < 1 || NUM_WATCH > 2) begin : g_bad_dbg
    $error("rpds_top: breakpoint or watchpoint count out of range");
  end
  // A minimum-width pin pulse must outlast the two-stage synchroniser
  if (PIN_PULSE_CYC < 2) begin : g_bad_pulse
    $error("rpds_top: reset pin pulse shorter than synchroniser");
  end

  // ****************************************************************
  // Types and state
  // ****************************************************************
  typedef enum logic [2:0] {
    SEQ_HOLD = 3'b001,
    SEQ_INIT = 3'b010,
    SEQ_RUN  = 3'b100
  } rpds_seq_t;

  rpds_seq_t             seq_reg;
  rpds_seq_t             seq_next;
  logic [N_SYNC-1:0]     meta_reg;
  logic [N_SYNC-1:0]     sync_reg;
  logic [1:0]            rsync_reg;
  logic                  bod_rst_reg;
  logic                  pin_low_prev_reg;
  logic                  was_dpd_reg;
  logic                  ctrl_pin_rst_reg;
  logic [1:0]            ctrl_clk_reg;
  logic                  ctrl_remap_reg;
  logic                  ctrl_isp_dis_reg;
  logic [2:0]            bod_cfg_reg;
  logic [3:0]            flags_reg;
  logic [3:0]            flags_next;
  logic                  bod_seen_reg;
  logic [1:0]            prot_reg;
  logic                  no_isp_reg;
  logic                  boot_entry_reg;
  logic [NUM_BKPT-1:0]   bkpt_reg;
  logic [NUM_WATCH-1:0]  watch_reg;
  logic                  flash_req_reg;
  logic                  cpu_start_reg;
  logic                  wake_reg;
  logic [DATA_W-1:0]     rdata_reg;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  wire logic [N_SYNC-1:0] async_in = {trst_n, boot_select_pin_n, brownout_below,
                                      por_req, wdt_reset_req, reset_capable_pin_n};

  // One pair of flops per asynchronous input; the first stage feeds only the second
  for (genvar i = 0; i < N_SYNC; i++) begin : g_sync
    always_ff @(posedge mclk) begin
      meta_reg[i] <= async_in[i];
      sync_reg[i] <= meta_reg[i];
    end
  end

  wire logic pin_high    = sync_reg[SY_PIN];
  wire logic boot_low    = ~sync_reg[SY_BOOT];
  wire logic trst_idle   = sync_reg[SY_TRST];

  // ****************************************************************
  // Reset source merge
  // ****************************************************************
  // Pin acts only with the reset function chosen and outside deep power-down
  wire logic pin_allowed = ctrl_pin_rst_reg & (power_mode != PM_DEEP_PD);
  wire logic pin_req_raw = pin_allowed & ~reset_capable_pin_n;
  wire logic pin_req_syn = pin_allowed & ~pin_high;
  wire logic bod_irq_lvl = bod_cfg_reg[BOD_IRQ_SEL] ? sync_reg[SY_BOD1] : sync_reg[SY_BOD0];
  wire logic bod_rst_lvl = bod_cfg_reg[BOD_RST_SEL] ? sync_reg[SY_BOD1] : sync_reg[SY_BOD0];
  // Raw sources trip the reset at once, so even a pulse between edges is caught
  wire logic src_async   = por_req | wdt_reset_req | pin_req_raw | bod_rst_reg;

  // Brownout reset request, registered so the async path sees a clean level
  always_ff @(posedge mclk) begin
    bod_rst_reg <= rstn & bod_cfg_reg[BOD_RST_EN] & bod_rst_lvl;
  end

  // Assert without a clock, release two edges after the sources clear
  always_ff @(posedge mclk or posedge src_async) begin
    if (src_async) begin
      rsync_reg <= 2'b00;
    end else if (!rstn) begin
      rsync_reg <= 2'b00;
    end else begin
      rsync_reg <= {rsync_reg[0], 1'b1};
    end
  end

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************
  wire logic src_clear = rsync_reg[1];

  // Hold, init flash, run; a done level left over from the last load is not trusted
  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg)
      SEQ_HOLD: begin
        if (src_clear) begin
          seq_next = SEQ_INIT;
        end
      end
      SEQ_INIT: begin
        if (!src_clear) begin
          seq_next = SEQ_HOLD;
        end else if (flash_init_done && !flash_req_reg) begin
          seq_next = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (!src_clear) begin
          seq_next = SEQ_HOLD;
        end
      end
      default: begin
        seq_next = SEQ_HOLD;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      seq_reg <= SEQ_HOLD;
    end else begin
      seq_reg <= seq_next;
    end
  end

  // Chip stays in reset until flash is ready, so nothing runs on stale state
  wire logic chip_run   = (seq_reg == SEQ_RUN) & src_clear;
  wire logic chip_in_rst = ~chip_run;
  wire logic init_entry = (seq_reg != SEQ_INIT) & (seq_next == SEQ_INIT);
  wire logic run_entry  = (seq_reg == SEQ_INIT) & (seq_next == SEQ_RUN);

  // Strobes to flash controller and processor
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flash_req_reg <= 1'b0;
      cpu_start_reg <= 1'b0;
    end else begin
      flash_req_reg <= init_entry;
      cpu_start_reg <= run_entry;
    end
  end

  // ****************************************************************
  // Pin wake and deep power-down tracking
  // ****************************************************************
  wire logic low_power = (power_mode == PM_SLEEP) | (power_mode == PM_DEEP_SLEEP)
                       | (power_mode == PM_POWER_DOWN);

  // Wake pulses once on the pin's falling sample in a sleep mode
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pin_low_prev_reg <= 1'b0;
      wake_reg         <= 1'b0;
      was_dpd_reg      <= 1'b0;
    end else begin
      pin_low_prev_reg <= pin_req_syn;
      wake_reg         <= pin_req_syn & ~pin_low_prev_reg & low_power;
      was_dpd_reg      <= (power_mode == PM_DEEP_PD);
    end
  end

  wire logic dpd_exit = was_dpd_reg & (power_mode != PM_DEEP_PD);

  // ****************************************************************
  // Register write decode
  // ****************************************************************
  wire logic wr_ctrl   = reg_wr & (reg_addr == OFS_CTRL);
  wire logic wr_status = reg_wr & (reg_addr == OFS_STATUS);
  wire logic wr_bod    = reg_wr & (reg_addr == OFS_BOD_CFG);
  wire logic wr_debug  = reg_wr & (reg_addr == OFS_DEBUG);

  // Control registers go back to defaults on every chip reset
  always_ff @(posedge mclk) begin
    if (!rstn || chip_in_rst) begin
      ctrl_pin_rst_reg <= RST_PIN_FUNC;
      ctrl_clk_reg     <= CLK_SRC_IRC;
      ctrl_remap_reg   <= RST_REMAP;
      ctrl_isp_dis_reg <= 1'b0;
      bod_cfg_reg      <= RST_BOD_CFG;
      bkpt_reg         <= '0;
      watch_reg        <= '0;
    end else begin
      if (dpd_exit) begin
        ctrl_clk_reg <= CLK_SRC_IRC;
      end else if (wr_ctrl) begin
        ctrl_clk_reg <= reg_wdata[CTRL_CLK_LO +: 2];
      end
      if (wr_ctrl) begin
        ctrl_pin_rst_reg <= reg_wdata[CTRL_PIN_RST];
        ctrl_remap_reg   <= reg_wdata[CTRL_REMAP];
        ctrl_isp_dis_reg <= reg_wdata[CTRL_ISP_DIS];
      end
      if (wr_bod) begin
        bod_cfg_reg <= reg_wdata[2:0];
      end
      if (wr_debug) begin
        bkpt_reg  <= reg_wdata[NUM_BKPT-1:0];
        watch_reg <= reg_wdata[DBG_WATCH_LO +: NUM_WATCH];
      end
    end
  end

  // ****************************************************************
  // Reset cause and brownout flags
  // ****************************************************************
  wire logic [3:0] cause = {bod_rst_reg, sync_reg[SY_POR], sync_reg[SY_WDT], pin_req_syn};

  // Sticky, write one to clear; a new event in the clear cycle wins
  always_comb begin
    flags_next = (flags_reg & ~(reg_wdata[ST_FLAGS_LO +: 4] & {4{wr_status}})) | cause;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flags_reg    <= 4'h0;
      bod_seen_reg <= 1'b0;
    end else begin
      flags_reg    <= flags_next;
      bod_seen_reg <= (bod_seen_reg & ~(wr_status & reg_wdata[ST_BOD_SEEN]))
                    | bod_irq_lvl;
    end
  end

  // ****************************************************************
  // Read protection
  // ****************************************************************
  wire logic [1:0] prot_decode = (flash_prot_word == PAT_PROT_L1) ? PROT_L1 :
                                 (flash_prot_word == PAT_PROT_L2) ? PROT_L2 :
                                 (flash_prot_word == PAT_PROT_L3) ? PROT_L3 : PROT_NONE;

  // Most restrictive after block reset until the flash word is first read; a chip reset keeps the last level
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prot_reg   <= PROT_L3;
      no_isp_reg <= 1'b1;
    end else if (run_entry) begin
      prot_reg   <= prot_decode;
      no_isp_reg <= (flash_prot_word == PAT_NO_ISP);
    end
  end

  // Boot pin is sampled once, on the edge that releases the chip
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      boot_entry_reg <= 1'b0;
    end else if (run_entry) begin
      boot_entry_reg <= boot_low & (prot_decode != PROT_L3)
                      & (flash_prot_word != PAT_NO_ISP);
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  wire logic [DATA_W-1:0] rd_ctrl   = {27'h0, ctrl_isp_dis_reg, ctrl_remap_reg, ctrl_clk_reg,
                                       ctrl_pin_rst_reg};
  wire logic [DATA_W-1:0] rd_status = {25'h0, scan_en, bod_seen_reg, bod_irq_lvl, flags_reg};
  wire logic [DATA_W-1:0] rd_bod    = {29'h0, bod_cfg_reg};
  wire logic [DATA_W-1:0] rd_debug  = {{(DATA_W-8-NUM_WATCH){1'b0}}, watch_reg,
                                       {(8-NUM_BKPT){1'b0}}, bkpt_reg};
  wire logic [DATA_W-1:0] rd_caps   = {24'h0, 4'(NUM_WATCH), 4'(NUM_BKPT)};
  wire logic [DATA_W-1:0] rd_prot   = {29'h0, no_isp_reg, prot_reg};
  wire logic [DATA_W-1:0] rd_mux    = (reg_addr == OFS_CTRL)    ? rd_ctrl   :
                                      (reg_addr == OFS_STATUS)  ? rd_status :
                                      (reg_addr == OFS_BOD_CFG) ? rd_bod    :
                                      (reg_addr == OFS_DEBUG)   ? rd_debug  :
                                      (reg_addr == OFS_CAPS)    ? rd_caps   :
                                      (reg_addr == OFS_PROT)    ? rd_prot   : '0;

  // Data stands for the one cycle after the strobe, zero otherwise
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : '0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata             = rdata_reg;
  assign chip_rst_n            = chip_run;
  assign reset_status_out      = chip_in_rst;
  // Oscillator runs through any reset and while it is the chosen source
  assign internal_rc_osc_en    = chip_in_rst | (ctrl_clk_reg == CLK_SRC_IRC);
  assign clk_src_sel           = ctrl_clk_reg;
  assign flash_init_req        = flash_req_reg;
  assign wake_req              = wake_reg;
  assign cpu_start             = cpu_start_reg;
  assign cpu_start_addr        = BOOT_FETCH_ADDR;
  assign boot_remap            = ctrl_remap_reg;
  assign brownout_irq          = bod_irq_lvl;
  // Pin high picks serial debug, only out of reset and unprotected
  assign swd_en                = chip_run & pin_high & (prot_reg == PROT_NONE);
  // Pin low picks boundary scan until the tester asserts TRST
  assign scan_en               = ~pin_high & trst_idle;
  assign core_debug_en         = swd_en;
  assign isp_level             = (prot_reg == PROT_L1) ? ISP_LIMITED :
                                 (prot_reg == PROT_L2) ? ISP_REDUCED :
                                 (prot_reg == PROT_L3) ? ISP_NONE : ISP_FULL;
  assign isp_sector0_lock      = (prot_reg == PROT_L1);
  assign isp_erase_only        = (prot_reg == PROT_L2);
  assign isp_boot_entry        = boot_entry_reg & ~ctrl_isp_dis_reg & ~no_isp_reg;
  assign in_app_programming_en = chip_run;
  assign bkpt_en               = bkpt_reg & {NUM_BKPT{core_debug_en}};
  assign watch_en              = watch_reg & {NUM_WATCH{core_debug_en}};

endmodule

// file: testbench/rpds_asserts.sv
// Checker for the reset, protection and debug-select block
module rpds_asserts
  import rpds_pkg::*;
(
  // ****************************************************************
  // Watched ports
  // ****************************************************************
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        por_req,
  input wire logic        wdt_reset_req,
  input wire logic        chip_rst_n,
  input wire logic        reset_status_out,
  input wire logic        internal_rc_osc_en,
  input wire logic        swd_en,
  input wire logic        scan_en,
  input wire logic        core_debug_en,
  input wire logic        flash_init_req,
  input wire logic        cpu_start,
  input wire logic [31:0] cpu_start_addr,
  input wire logic        in_app_programming_en,
  input wire logic [3:0]  bkpt_en
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Reset merge; the chip reset trips in the same cycle as its source
  por_rst_a: assert property (por_req |-> !chip_rst_n)
    else $error("power-on request left chip running");
  wdt_rst_a: assert property (wdt_reset_req |-> !chip_rst_n)
    else $error("watchdog request left chip running");
  status_out_a: assert property (reset_status_out != chip_rst_n)
    else $error("reset status output disagrees with chip reset");
  init_pulse_a: assert property (flash_init_req |-> !chip_rst_n ##1 !flash_init_req)
    else $error("flash init request outside reset or too long");
  start_fetch_a: assert property ($rose(chip_rst_n) |-> ##[0:1] (cpu_start && cpu_start_addr == 32'h0000_0000))
    else $error("no start at address zero after release");
  swd_hold_a: assert property (!chip_rst_n |-> !swd_en)
    else $error("serial debug enabled during reset");
  port_sel_a: assert property (scan_en |-> !swd_en && !core_debug_en)
    else $error("scan and debug active together");
  irc_reset_a: assert property (!chip_rst_n |-> internal_rc_osc_en)
    else $error("rc oscillator off during reset");
  iap_free_a: assert property (in_app_programming_en == chip_rst_n)
    else $error("in-app programming gated wrongly");
  bkpt_gate_a: assert property (!core_debug_en |-> bkpt_en == 4'h0)
    else $error("breakpoints live without debug");
endmodule

// file: testbench/rpds_flash_model.sv
// Flash controller model: loads the protection word after each request
module rpds_flash_model (
  input  wire logic        mclk,
  input  wire logic        flash_init_req,
  input  wire logic [31:0] prot_word,
  input  wire logic [3:0]  lat,
  output logic             flash_init_done,
  output logic [31:0]      flash_prot_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  initial begin
    cnt = 4'h0;
    flash_init_done = 1'b0;
  end
  // Ready drops on a request and returns after lat cycles, so slow loads are seen
  always @(posedge mclk) begin
    if (flash_init_req) begin
      flash_init_done <= 1'b0;
      cnt <= lat;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      flash_init_done <= (cnt == 4'h1);
    end
  end
  // Word valid only with ready; inverse otherwise so a stale read shows up
  assign flash_prot_word = flash_init_done ? prot_word : ~prot_word;
endmodule

// file: testbench/rpds_tb_top.sv
// Self-checking bench for the reset, protection and debug-select block
module reset_protect_debug_select_tb_top import rpds_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rstn, reg_wr, reg_rd, reset_capable_pin_n, wdt_reset_req, por_req;
  logic boot_select_pin_n, trst_n, flash_init_done, flash_init_req, chip_rst_n, woke;
  logic reset_status_out, internal_rc_osc_en, wake_req, cpu_start, boot_remap, swd_en;
  logic brownout_irq, scan_en, core_debug_en, isp_sector0_lock, isp_erase_only;
  logic isp_boot_entry, in_app_programming_en;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, flash_prot_word, cpu_start_addr, word, d;
  logic [1:0]  brownout_below, clk_src_sel, isp_level, watch_en;
  logic [2:0]  power_mode;
  logic [3:0]  bkpt_en, lat;
  int          err_total, tests_run;
  rpds_top dut (.*);
  rpds_flash_model u_flash (.mclk(mclk), .flash_init_req(flash_init_req), .prot_word(word),
    .lat(lat), .flash_init_done(flash_init_done), .flash_prot_word(flash_prot_word));
  // Clock and wake pulse catcher; a one-cycle pulse is easy to miss otherwise
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) if (wake_req === 1'b1) woke <= 1'b1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    v = reg_rdata;
  endtask
  // Bounded wait for the chip to leave reset
  task automatic wait_run();
    for (int i = 0; i < 64 && chip_rst_n !== 1'b1; i++) @(posedge mclk);
    if (chip_rst_n !== 1'b1) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic pin_low(input int n);
    @(posedge mclk);
    reset_capable_pin_n <= 1'b0;
    cyc(n);
    reset_capable_pin_n <= 1'b1;
  endtask
  task automatic por_boot(input logic [31:0] w);
    word <= w;
    lat <= 4'($urandom_range(8, 1));
    @(posedge mclk);
    por_req <= 1'b1;
    cyc(3);
    por_req <= 1'b0;
    wait_run();
  endtask
  initial begin
    {rstn, reg_wr, reg_rd, wdt_reset_req, por_req, boot_select_pin_n, woke} = '0;
    {reset_capable_pin_n, trst_n, lat} = 6'h3F;
    {reg_addr, reg_wdata, word, brownout_below, power_mode} = '0;
    {err_total, tests_run} = '0;
    void'($urandom(59));
    cyc(5);
    rstn <= 1'b1;
    wait_run();
    // Every protection pattern with the boot pin requesting programming entry
    for (int w = 0; w < 5; w++) begin
      por_boot(32'(w));
      chk(isp_level, 32'(w % 4));
      chk(swd_en, 32'(w % 4 == 0));
      chk({isp_erase_only, isp_sector0_lock}, 32'(w == 1 ? 1 : w == 2 ? 2 : 0));
      chk(isp_boot_entry, 32'(w < 3));
      rd(OFS_PROT, d);
      chk(d[2:0], 32'(w));
    end
    @(posedge mclk);
    wdt_reset_req <= 1'b1;
    cyc($urandom_range(4, 1));
    wdt_reset_req <= 1'b0;
    wait_run();
    rd(OFS_STATUS, d);
    chk(d[1], 1);
    // Shortest legal pin pulse while asleep: reset plus wake
    power_mode <= PM_SLEEP;
    pin_low(PIN_PULSE_CYC);
    chk(chip_rst_n, 0);
    wait_run();
    rd(OFS_STATUS, d);
    chk({woke, d[0]}, 2'b11);
    power_mode <= PM_DEEP_PD;
    pin_low(8);
    cyc(1);
    chk(chip_rst_n, 1);
    power_mode <= PM_ACTIVE;
    // Pin function deselected: low pin only picks the scan port
    wr(OFS_CTRL, 32'h0000_0008);
    cyc(1);
    reset_capable_pin_n <= 1'b0;
    cyc(4);
    chk({scan_en, swd_en, chip_rst_n}, 3'b101);
    rd(OFS_STATUS, d);
    chk({d[6], scan_en}, 2'b11);
    // Tester ends the scan with TRST, then lets the pin go high for serial debug
    trst_n <= 1'b0;
    cyc(4);
    chk(scan_en, 0);
    {trst_n, reset_capable_pin_n} <= 2'b11;
    cyc(3);
    chk(swd_en, 1);
    // Brownout level select, status view, then forced reset at level one
    brownout_below <= 2'b10;
    for (int s = 0; s < 2; s++) begin
      wr(OFS_BOD_CFG, 32'(s));
      cyc(3);
      chk(brownout_irq, 32'(s));
    end
    rd(OFS_STATUS, d);
    chk(d[5:4], 2'b11);
    wr(OFS_BOD_CFG, 32'h0000_0006);
    cyc(3);
    chk(chip_rst_n, 0);
    brownout_below <= 2'b00;
    wait_run();
    rd(OFS_CAPS, d);
    chk(d, 32'h0000_0024);
    wr(OFS_DEBUG, 32'h0000_0305);
    rd(OFS_DEBUG, d);
    chk({d[9:8], d[3:0], watch_en, bkpt_en}, 12'hD75);
    rd(8'h20, d);
    chk(d, 0);
    chk({clk_src_sel, boot_remap}, 3'b001);
    complete_run();
  end
endmodule
bind rpds_top rpds_asserts u_chk (.*);
